// >>> inc/gtc_defines.svh
// Register offsets, field positions and reset values of the gated timer
`ifndef GTC_DEFINES_SVH
`define GTC_DEFINES_SVH

`define GTC_OFF_CNT_LO 8'h00
`define GTC_OFF_CNT_HI 8'h04
`define GTC_OFF_CTL 8'h08
`define GTC_OFF_GATE 8'h0C
`define GTC_OFF_IRQ_STAT 8'h10
`define GTC_OFF_IRQ_CLR 8'h14
`define GTC_OFF_IRQ_EN 8'h18

`define GTC_CTL_ON 0
`define GTC_CTL_SYNC 2
`define GTC_CTL_OSC 3
`define GTC_CTL_PS_LO 4
`define GTC_CTL_CS_LO 6
`define GTC_CTL_MASK 8'hFD

`define GTC_GATE_GSS_LO 0
`define GTC_GATE_VAL 2
`define GTC_GATE_POL 6
`define GTC_GATE_GE 7

`define GTC_IRQ_OVF 0
`define GTC_IRQ_GATE 1
`define GTC_IRQ_W 2

`define GTC_CNT_MAX 16'hFFFF
`define GTC_CNT_RST 16'h0000
`define GTC_BYTE_RST 8'h00
`define GTC_INST_DIV_LAST 2'h3

`endif

// >>> inc/gtc_pkg.sv
// Types shared by the gated timer modules
`default_nettype none
package gtc_pkg;
  typedef enum logic [1:0] {
    GTC_CS_INST = 2'b00,
    GTC_CS_SYS = 2'b01,
    GTC_CS_EXT = 2'b10,
    GTC_CS_LFO = 2'b11
  } gtc_clk_sel_t;

  typedef enum logic [1:0] {
    GTC_GS_PIN = 2'b00,
    GTC_GS_T0OVF = 2'b01,
    GTC_GS_CMP1 = 2'b10,
    GTC_GS_CMP2 = 2'b11
  } gtc_gate_src_t;
endpackage
`default_nettype wire

// >>> inc/gtc_src_if.sv
// Link between the timer core and its count source selector
`default_nettype none
interface gtc_src_if;
  import gtc_pkg::*;
  gtc_clk_sel_t sel;
  logic osc_en;
  logic run;
  logic rearm;
  logic tick;

  modport core (output sel, output osc_en, output run, output rearm, input tick);
  modport source (input sel, input osc_en, input run, input rearm, output tick);
endinterface
`default_nettype wire

// >>> rtl/gtc_src_sel.sv
// Count source selection, pin synchronisers and edge detection
`include "gtc_defines.svh"
`default_nettype none
module gtc_src_sel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic count_pin,
  input wire logic sosc_clk,
  input wire logic lfosc_clk,
  gtc_src_if.source src
);
  import gtc_pkg::*;

  // Index 0: count pin, 1: crystal oscillator, 2: low-frequency oscillator
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;
  logic [1:0] div;
  logic armed;
  logic tick;
  logic [1:0] next_div;
  logic next_armed;
  logic next_tick;
  logic ext_lvl;
  logic ext_rise;

  always_comb
  begin
    next_div = div + 2'h1;
    ext_lvl = src.osc_en ? sync2[1] : sync2[0];
    ext_rise = src.osc_en ? (sync2[1] & ~prev[1]) : (sync2[0] & ~prev[0]);
    if (src.rearm || !src.run)
      next_armed = 1'b0;
    else if (!ext_lvl)
      next_armed = 1'b1;
    else
      next_armed = armed;
    unique case (src.sel)
      GTC_CS_INST: next_tick = (div == `GTC_INST_DIV_LAST);
      GTC_CS_SYS: next_tick = 1'b1;
      GTC_CS_EXT: next_tick = ext_rise & armed & ~src.rearm;
      GTC_CS_LFO: next_tick = sync2[2] & ~prev[2];
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev <= 3'h0;
      div <= 2'h0;
      armed <= 1'b0;
      tick <= 1'b0;
    end
    else
    begin
      sync1 <= {lfosc_clk, sosc_clk, count_pin};
      sync2 <= sync1;
      prev <= sync2;
      div <= next_div;
      armed <= next_armed;
      tick <= next_tick;
    end
  end

  assign src.tick = tick;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_inst_tick_rate: assert property ((src.sel == GTC_CS_INST) && next_tick |=> ((src.sel != GTC_CS_INST) || !next_tick) [*3])
    else $error("instruction clock tick came sooner than four clocks");
  a_ext_needs_arm: assert property ((src.sel == GTC_CS_EXT) && next_tick |-> armed && !src.rearm)
    else $error("external tick without a prior falling edge");
  a_sync_depth: assert property (sync2[0] == $past(count_pin, 2))
    else $error("count pin not seen through two stages");
endmodule // gtc_src_sel
`default_nettype wire

// >>> rtl/gtc_timer.sv
// Gated 16-bit timer/counter with AHB-Lite register slave
// What this block does
// - 16-bit up-counter read and written as two bytes; writes replace the byte.
// - Off when on bit clear; on bit alone counts; with gate enable, gate governs.
// - Clock select: 00 clock/4, 01 system clock, 10 count pin or crystal per oscillator enable bit, 11 slow oscillator.
// - System clock or slow oscillator source advances every rising edge, before prescaling.
// - Instruction clock source advances once per four system clocks.
// - Count pin advances on rising edge, always through two synchroniser stages whatever the sync bit.
// - A falling edge must precede the first counted edge after enable or write.
// - Oscillator enable bit starts the secondary crystal oscillator, kept running in sleep.
// - Prescale field divides the selected count clock by 1, 2, 4 or 8.
// - Prescale counter hidden from software, cleared on any count byte write.
// - Reading the count on fast sources may see a carry between the two byte reads.
// - Count wraps FFFFh to 0000h and sets the overflow flag, cleared by software.
// - With gating, count only while gate level equals polarity bit, else hold.
// - Sync bit set lets the timer run and wake during sleep; synchronisation stays in place.
// - Gate source: 00 gate pin, 01 timer0 overflow, 10 comparator 1, 11 comparator 2.
`include "gtc_defines.svh"
`default_nettype none
module gtc_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic count_pin,
  input wire logic sosc_clk,
  input wire logic lfosc_clk,
  input wire logic gate_pin,
  input wire logic t0_overflow,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic sleep_mode,
  output logic osc_enable,
  output logic irq
);
  import gtc_pkg::*;

  gtc_src_if src ();

  gtc_src_sel u_src (
    .hclk(hclk),
    .hresetn(hresetn),
    .count_pin(count_pin),
    .sosc_clk(sosc_clk),
    .lfosc_clk(lfosc_clk),
    .src(src.source)
  );

  // Bus state
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic [7:0] next_addr;
  logic next_wr_pend;
  logic next_rd_pend;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic take;

  // Timer state
  logic [15:0] cnt;
  logic [2:0] psc;
  logic [7:0] ctl;
  logic gate_en;
  logic gate_pol;
  gtc_gate_src_t gate_src;
  logic [2:0] gsync1;
  logic [2:0] gsync2;
  logic gate_val;
  logic [`GTC_IRQ_W-1:0] status;
  logic [`GTC_IRQ_W-1:0] irq_en;
  logic [15:0] next_cnt;
  logic [2:0] next_psc;
  logic [7:0] next_ctl;
  logic next_gate_en;
  logic next_gate_pol;
  gtc_gate_src_t next_gate_src;
  logic next_gate_val;
  logic [`GTC_IRQ_W-1:0] next_status;
  logic [`GTC_IRQ_W-1:0] next_irq_en;
  logic next_irq;

  logic wr_lo;
  logic wr_hi;
  logic wr_any;
  logic gate_ok;
  logic run;
  logic adv;
  logic [`GTC_IRQ_W-1:0] events;
  logic [`GTC_IRQ_W-1:0] clr_bits;

  function automatic logic psc_hit(input logic [2:0] c, input logic [1:0] sel);
    logic h;
    h = 1'b1;
    unique case (sel)
      2'b00: h = 1'b1;
      2'b01: h = c[0];
      2'b10: h = &c[1:0];
      2'b11: h = &c;
    endcase
    return h;
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `GTC_OFF_CNT_LO: r[7:0] = cnt[7:0];
      `GTC_OFF_CNT_HI: r[7:0] = cnt[15:8];
      `GTC_OFF_CTL: r[7:0] = ctl;
      `GTC_OFF_GATE:
      begin
        r[`GTC_GATE_GE] = gate_en;
        r[`GTC_GATE_POL] = gate_pol;
        r[`GTC_GATE_VAL] = gate_val;
        r[`GTC_GATE_GSS_LO +: 2] = gate_src;
      end
      `GTC_OFF_IRQ_STAT: r[`GTC_IRQ_W-1:0] = status;
      `GTC_OFF_IRQ_EN: r[`GTC_IRQ_W-1:0] = irq_en;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Bus slave: writes finish in one data-phase cycle, reads add one wait state
  always_comb
  begin
    take = hsel & htrans[1] & hready;
    next_addr = take ? haddr[7:0] : addr_q;
    next_wr_pend = hready ? (take & hwrite) : wr_pend;
    next_rd_pend = take & ~hwrite;
    next_hreadyout = ~(take & ~hwrite);
    next_hrdata = rd_pend ? read_mux(addr_q) : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q <= `GTC_BYTE_RST;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end
    else
    begin
      addr_q <= next_addr;
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      hreadyout <= next_hreadyout;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
    end
  end

  // Timer core
  always_comb
  begin
    wr_lo = wr_pend && (addr_q == `GTC_OFF_CNT_LO);
    wr_hi = wr_pend && (addr_q == `GTC_OFF_CNT_HI);
    wr_any = wr_lo | wr_hi;
    unique case (gate_src)
      GTC_GS_PIN: next_gate_val = gsync2[0];
      GTC_GS_T0OVF: next_gate_val = t0_overflow;
      GTC_GS_CMP1: next_gate_val = gsync2[1];
      GTC_GS_CMP2: next_gate_val = gsync2[2];
    endcase
    gate_ok = (gate_val == gate_pol);
    run = ctl[`GTC_CTL_ON] & (~gate_en | gate_ok) & ~(sleep_mode & ~ctl[`GTC_CTL_SYNC]);
    adv = 1'b0;
    next_psc = psc;
    if (wr_any)
      next_psc = 3'h0;
    // divide by 1, 2, 4 or 8
    else if (src.tick && run)
    begin
      if (psc_hit(psc, ctl[`GTC_CTL_PS_LO +: 2]))
      begin
        next_psc = 3'h0;
        adv = 1'b1;
      end
      else
        next_psc = psc + 3'h1;
    end
    next_cnt = adv ? cnt + 16'h0001 : cnt;
    if (wr_lo)
      next_cnt[7:0] = hwdata[7:0];
    if (wr_hi)
      next_cnt[15:8] = hwdata[7:0];
    next_ctl = ctl;
    next_gate_en = gate_en;
    next_gate_pol = gate_pol;
    next_gate_src = gate_src;
    next_irq_en = irq_en;
    if (wr_pend && (addr_q == `GTC_OFF_CTL))
      next_ctl = hwdata[7:0] & `GTC_CTL_MASK;
    if (wr_pend && (addr_q == `GTC_OFF_GATE))
    begin
      next_gate_en = hwdata[`GTC_GATE_GE];
      next_gate_pol = hwdata[`GTC_GATE_POL];
      next_gate_src = gtc_gate_src_t'(hwdata[`GTC_GATE_GSS_LO +: 2]);
    end
    if (wr_pend && (addr_q == `GTC_OFF_IRQ_EN))
      next_irq_en = hwdata[`GTC_IRQ_W-1:0];
    clr_bits = (wr_pend && (addr_q == `GTC_OFF_IRQ_CLR)) ? hwdata[`GTC_IRQ_W-1:0] : 2'b00;
    events[`GTC_IRQ_OVF] = adv && (cnt == `GTC_CNT_MAX);
    events[`GTC_IRQ_GATE] = gate_val & ~next_gate_val;
    next_status = (status & ~clr_bits) | events;
    next_irq = |(next_status & next_irq_en);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= `GTC_CNT_RST;
      psc <= 3'h0;
      ctl <= `GTC_BYTE_RST;
      gate_en <= 1'b0;
      gate_pol <= 1'b0;
      gate_src <= GTC_GS_PIN;
      gsync1 <= 3'h0;
      gsync2 <= 3'h0;
      gate_val <= 1'b0;
      status <= 2'b00;
      irq_en <= 2'b00;
      irq <= 1'b0;
      osc_enable <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      psc <= next_psc;
      ctl <= next_ctl;
      gate_en <= next_gate_en;
      gate_pol <= next_gate_pol;
      gate_src <= next_gate_src;
      gsync1 <= {cmp2_out, cmp1_out, gate_pin};
      gsync2 <= gsync1;
      gate_val <= next_gate_val;
      status <= next_status;
      irq_en <= next_irq_en;
      irq <= next_irq;
      osc_enable <= next_ctl[`GTC_CTL_OSC];
    end
  end

  assign src.sel = gtc_clk_sel_t'(ctl[`GTC_CTL_CS_LO +: 2]);
  assign src.osc_en = ctl[`GTC_CTL_OSC];
  assign src.run = ctl[`GTC_CTL_ON];
  assign src.rearm = wr_any;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (take && !hwrite |=> s_rd_wait)
    else $error("read did not answer after one wait state");
  a_byte_low: assert property (wr_lo && !wr_hi |=> cnt[7:0] == $past(hwdata[7:0]))
    else $error("low count byte not replaced by write");
  a_off_holds: assert property (!ctl[`GTC_CTL_ON] && !wr_any |=> cnt == $past(cnt))
    else $error("count moved while timer off");
  a_sys_rate: assert property ((src.sel == GTC_CS_SYS) && src.tick && run && !wr_any
    && (ctl[`GTC_CTL_PS_LO +: 2] == 2'b00) |=> cnt == $past(cnt) + 16'h0001)
    else $error("system clock source did not advance count");
  a_osc_follow: assert property (wr_pend && (addr_q == `GTC_OFF_CTL) |=> osc_enable == $past(hwdata[3]))
    else $error("oscillator enable does not follow control write");
  a_psc_clear: assert property (wr_any |=> psc == 3'h0 ##1 psc <= 3'h1)
    else $error("prescaler not cleared by count write");
  a_wrap_flag: assert property ((cnt == `GTC_CNT_MAX) && adv |=> cnt == `GTC_CNT_RST && status[0] ##1 status[0]
    || $past(clr_bits[0]))
    else $error("wrap did not set overflow flag");
  a_gate_holds: assert property (ctl[`GTC_CTL_ON] && gate_en && !gate_ok && !wr_any |=> $stable(cnt))
    else $error("count moved while gate closed");
  a_sleep_sync: assert property (sleep_mode && !ctl[`GTC_CTL_SYNC] && !wr_any |=> $stable(cnt))
    else $error("synchronised timer advanced during sleep");
  a_irq_level: assert property ((status & irq_en) != 2'b00 && $stable(status) && $stable(irq_en) |-> irq)
    else $error("interrupt low with enabled status set");
  a_byte_high: assert property (wr_hi && !wr_lo |=> cnt[15:8] == $past(hwdata[7:0]))
    else $error("high count byte not replaced by write");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase inserted a wait state");
  a_hrdata_holds: assert property (!rd_pend |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_ctl_write: assert property (wr_pend && (addr_q == `GTC_OFF_CTL)
    |=> ctl == ($past(hwdata[7:0]) & `GTC_CTL_MASK))
    else $error("control write not stored");

  // Prescale and source steps
  a_always_on: assert property (ctl[`GTC_CTL_ON] && !gate_en && !sleep_mode && src.tick && !wr_any
    && (ctl[`GTC_CTL_PS_LO +: 2] == 2'b00) |=> cnt == $past(cnt) + 16'h0001)
    else $error("ungated timer did not count its tick");
  a_div2_skip: assert property (src.tick && run && !wr_any && !psc[0]
    && (ctl[`GTC_CTL_PS_LO +: 2] == 2'b01) |=> $stable(cnt) && psc == $past(psc) + 3'h1)
    else $error("divide by two prescaler advanced early");
  a_div8_step: assert property (src.tick && run && !wr_any && (psc == 3'h7)
    && (ctl[`GTC_CTL_PS_LO +: 2] == 2'b11) |=> cnt == $past(cnt) + 16'h0001 && psc == 3'h0)
    else $error("divide by eight prescaler missed its eighth tick");
  a_tick_idle: assert property (!src.tick && !wr_any |=> $stable(cnt) && $stable(psc))
    else $error("count or prescaler moved without a source tick");
  a_async_sleep: assert property (sleep_mode && ctl[`GTC_CTL_SYNC] && ctl[`GTC_CTL_ON] && !gate_en
    && src.tick && !wr_any && (ctl[`GTC_CTL_PS_LO +: 2] == 2'b00) |=> cnt == $past(cnt) + 16'h0001)
    else $error("unsynchronised timer stopped during sleep");

  // Gate level paths and flags
  a_gate_pin_path: assert property (gate_src == GTC_GS_PIN |=> gate_val == $past(gate_pin, 3))
    else $error("gate pin level not seen through three stages");
  a_gate_t0_path: assert property (gate_src == GTC_GS_T0OVF |=> gate_val == $past(t0_overflow))
    else $error("timer0 overflow not taken as gate level");
  a_gate_c1_path: assert property (gate_src == GTC_GS_CMP1 |=> gate_val == $past(cmp1_out, 3))
    else $error("comparator 1 level not seen through three stages");
  a_gate_c2_path: assert property (gate_src == GTC_GS_CMP2 |=> gate_val == $past(cmp2_out, 3))
    else $error("comparator 2 level not seen through three stages");
  a_gate_event: assert property (gate_val && !next_gate_val |=> status[`GTC_IRQ_GATE])
    else $error("gate falling edge did not set its status bit");
  a_ovf_clear: assert property (clr_bits[`GTC_IRQ_OVF] && !events[`GTC_IRQ_OVF] |=> !status[`GTC_IRQ_OVF])
    else $error("overflow flag survived its clear");
  a_ovf_set_wins: assert property (events[`GTC_IRQ_OVF] |=> status[`GTC_IRQ_OVF])
    else $error("overflow event lost against a clear");
endmodule // gtc_timer
`default_nettype wire

// >>> sim/gtc_pulse_src.sv
// Model of the far side: count pin event source and secondary crystal
`default_nettype none
module gtc_pulse_src (
  input wire logic hclk,
  input wire logic osc_enable,
  output logic count_pin,
  output logic sosc_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;

  initial
  begin
    count_pin = 1'b0;
    sosc_clk = 1'b0;
  end

  // rising edges, each frame opened from a low idle level
  task automatic burst(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge hclk);
      count_pin <= 1'b1;
      repeat (half) @(posedge hclk);
      count_pin <= 1'b0;
    end
  endtask

  // crystal runs with an eight clock period only while enabled
  always @(posedge hclk)
  begin
    ph <= osc_enable ? ph + 1 : 0;
    if (osc_enable && ph % 4 == 3)
      sosc_clk <= ~sosc_clk;
  end
endmodule // gtc_pulse_src
`default_nettype wire

// >>> sim/tb_gtc_timer.sv
// Self-checking bench for the gated timer against an integer model
`default_nettype none
`include "gtc_defines.svh"
module tb_gtc_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout, hresp, count_pin, sosc_clk, osc_enable, irq;
  logic lfosc_clk = 1'b0;
  logic sleep_mode = 1'b0;
  logic [3:0] gsrc = 4'h0;
  logic [3:0] gheld = 4'hF;
  logic [3:0] gval = 4'h0;
  // Random stream starts at 96233
  logic [16:0] lfsr = 17'h1_77E9;
  int cyc = 0;
  int tests_run = 0;
  int miscompares = 0;

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  always #25 hclk = ~hclk;

  // Slow oscillator of eight clocks; unpinned gate lines toggle randomly
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3)
      lfosc_clk <= ~lfosc_clk;
    lfsr <= lfsr_next(lfsr);
    gsrc <= (gval & gheld) | (lfsr[3:0] & ~gheld);
  end

  gtc_timer gtc_timer_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .count_pin(count_pin), .sosc_clk(sosc_clk), .lfosc_clk(lfosc_clk),
    .gate_pin(gsrc[0]), .t0_overflow(gsrc[1]), .cmp1_out(gsrc[2]), .cmp2_out(gsrc[3]),
    .sleep_mode(sleep_mode), .osc_enable(osc_enable), .irq(irq)
  );

  gtc_pulse_src gtc_pulse_src_i (.hclk(hclk), .osc_enable(osc_enable), .count_pin(count_pin), .sosc_clk(sosc_clk));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
    tests_run++;
    if (seen !== exp_v)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp_v);
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] %0t bus answer timed out", $time);
    end
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, {24'h00_0000, d}, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(a, 1'b0, 32'h0000_0000, r);
  endtask

  // Low byte advance over exactly 128 clocks, aligned to the bench counter
  task automatic span(input int per64, input int ps);
    logic [31:0] a, b;
    repeat (8) @(posedge hclk);
    while (cyc % 64 != 0) @(posedge hclk);
    rd(`GTC_OFF_CNT_LO, a);
    repeat (100) @(posedge hclk);
    while (cyc % 64 != 0) @(posedge hclk);
    rd(`GTC_OFF_CNT_LO, b);
    check(b, (a + ((2 * per64) >> ps)) & 32'h0000_00FF);
  endtask

  initial
  begin
    logic [31:0] r;
    logic [15:0] v;
    int n;
    int rate[4];
    rate = '{16, 64, 8, 8};
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // all registers clear, unmapped offset reads zero
    for (int a = 0; a <= 32'h1C; a += 4)
    begin
      rd(8'(a), r);
      check(r & 32'hFFFF_FFFB, 32'h0000_0000);
    end
    check({hresp, irq, osc_enable}, 32'h0000_0000);
    // random count written byte by byte
    v = lfsr[15:0];
    wr(`GTC_OFF_CNT_HI, v[15:8]);
    wr(`GTC_OFF_CNT_LO, v[7:0]);
    rd(`GTC_OFF_CNT_HI, r);
    check(r, {24'h00_0000, v[15:8]});
    rd(`GTC_OFF_CNT_LO, r);
    check(r, {24'h00_0000, v[7:0]});
    wr(`GTC_OFF_CTL, 8'h0E);
    rd(`GTC_OFF_CTL, r);
    check(r, 32'h0000_000C);
    check(osc_enable, 32'h0000_0001);
    for (int cs = 0; cs < 4; cs++)
      for (int ps = 0; ps < 4; ps++)
      begin
        wr(`GTC_OFF_CTL, 8'((cs << 6) | (ps << 4) | ((cs == 2) ? 8 : 0) | 1));
        span(rate[cs], ps);
      end
    // pin pulses with sync bit and sleep
    for (int k = 0; k < 8; k++)
    begin
      wr(`GTC_OFF_CTL, 8'(8'h81 | ((k % 4) << 4) | ((k / 4) << 2)));
      wr(`GTC_OFF_CNT_HI, 8'h00);
      wr(`GTC_OFF_CNT_LO, 8'h00);
      sleep_mode <= k % 2;
      gtc_pulse_src_i.burst(13, 2 + 3 * (k % 2));
      repeat (8) @(posedge hclk);
      sleep_mode <= 1'b0;
      rd(`GTC_OFF_CNT_LO, r);
      check(r, (k % 2 == 1 && k < 4) ? 0 : 13 >> (k % 4));
    end
    // preset FC00h and time the wrap
    wr(`GTC_OFF_CTL, 8'h00);
    wr(`GTC_OFF_IRQ_CLR, 8'h03);
    wr(`GTC_OFF_IRQ_EN, 8'h01);
    wr(`GTC_OFF_CNT_HI, 8'hFC);
    wr(`GTC_OFF_CNT_LO, 8'h00);
    wr(`GTC_OFF_CTL, 8'h41);
    n = 0;
    while (irq !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
    check(n >= 1024 && n <= 1032, 32'h0000_0001);
    rd(`GTC_OFF_CNT_HI, r);
    check(r, 32'h0000_0000);
    // Status ignores writes, mask drops the line, clear empties it
    wr(`GTC_OFF_IRQ_STAT, 8'h00);
    wr(`GTC_OFF_IRQ_EN, 8'h00);
    rd(`GTC_OFF_IRQ_STAT, r);
    check(r, 32'h0000_0001);
    check(irq, 32'h0000_0000);
    wr(`GTC_OFF_CTL, 8'h00);
    wr(`GTC_OFF_IRQ_CLR, 8'h01);
    rd(`GTC_OFF_IRQ_STAT, r);
    check(r, 32'h0000_0000);
    for (int g = 0; g < 16; g++)
    begin
      gheld <= 4'h1 << (g / 4);
      gval <= (g % 2 == 1) ? 4'hF : 4'h0;
      wr(`GTC_OFF_GATE, 8'(8'h80 | (((g / 2) % 2) << 6) | (g / 4)));
      wr(`GTC_OFF_CTL, 8'h41);
      span((g % 2 == (g / 2) % 2) ? 64 : 0, 0);
      rd(`GTC_OFF_GATE, r);
      check(r, 32'(8'h80 | (((g / 2) % 2) << 6) | ((g % 2) << 2) | (g / 4)));
    end
    // Falling gate level raises the gate event flag
    wr(`GTC_OFF_IRQ_CLR, 8'h03);
    gval <= 4'h0;
    repeat (8) @(posedge hclk);
    rd(`GTC_OFF_IRQ_STAT, r);
    check(r, 32'h0000_0002);
    wr(`GTC_OFF_CTL, 8'h40);
    span(0, 0);
    summarize;
  end

  initial
  begin
    repeat (30000) @(posedge hclk);
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize;
  end
endmodule // tb_gtc_timer
`default_nettype wire
